// file: verilog/pin_mode_pkg.sv
package pin_mode_pkg;

  // Bus personality chosen by the strap at the end of reset.
  typedef enum logic {MODE_ISA, MODE_PCMCIA} bus_mode_t;

  // Default base of the sixteen-location I/O window, on address bits 15:4.
  localparam logic [11:0] IO_BASE_RST = 12'h030;
  // Default base of the boot ROM window, on address bits 19:14.
  localparam logic [5:0] ROM_BASE_RST = 6'h33;
  localparam int ROM_SHIFT = 14;
  // Attribute addresses with this bit low belong to the external flash.
  localparam int ATTR_SPLIT_BIT = 15;

  // Host pins as sampled, with the address pins shared by both modes.
  typedef struct packed {
    logic [19:0] addr;
    logic aen_reg_n;
    logic sbhe_ce2_n;
    logic bale_we_n;
    logic iord_n;
    logic iowr_n;
    logic memr_oe_n;
    logic [15:0] data;
  } host_in_t;

  // Pin drive toward the host, each two-way pin as output plus enable.
  typedef struct packed {
    logic mode_strap_pin_out;
    logic mode_strap_pin_oe;
    logic a10_out;
    logic a10_oe;
    logic a11_out;
    logic a11_oe;
    logic ready_out;
    logic ready_oe;
    logic [15:0] data_out;
    logic data_oe;
  } host_out_t;

  // Requests toward the register core.
  typedef struct packed {
    logic mode_valid;
    logic pcmcia;
    logic rd;
    logic wr;
    logic attr_rd;
    logic attr_wr;
    logic [14:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } core_out_t;

  // Whole state of the decoder.
  typedef struct packed {
    logic latched;
    bus_mode_t mode;
    logic rd_act;
    logic wr_act;
    logic we_act;
    host_out_t pins;
    core_out_t core;
  } state_t;

  localparam state_t ST_RST = '0;

endpackage

// file: verilog/pin_mode_decode.sv
`timescale 1ns/100ps
// What this block does
// - Sample the strap after reset; low means PCMCIA, high or open means ISA.
// - ISA mode drives the strap pin as boot ROM select on MEMR and ROM address.
// - ISA mode reads address pins 10, 11 and 19 as plain address inputs.
// - PCMCIA flash write strobe is low exactly when WE is low and program enable is set.
// - PCMCIA reads the address 19 pin as card enable 1 for even bytes.
// - PCMCIA reads the byte high enable pin as card enable 2 for odd bytes.
// - ISA I/O decoding happens only while AEN is low; the boot ROM select does not look at AEN.
// - The ready or wait pin is pulled to not-ready to stretch a host cycle.
// - Sixteen-bit data bus is driven only during the block's own reads.
// - PCMCIA drives the address 10 and 11 pins as flash strobe and select.
// - The mode is latched once per reset and then held.
// - PCMCIA WE writes configuration registers and attribute memory.
module pin_mode_decode
  import pin_mode_pkg::*;
#(
  parameter logic [11:0] IO_BASE = IO_BASE_RST,
  parameter logic [5:0] ROM_BASE = ROM_BASE_RST
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire host_in_t host_i,
  input wire logic mode_strap_pin_in,
  input wire logic flash_program_enable_bit,
  input wire logic core_busy,
  input wire logic [15:0] core_rdata,
  output host_out_t host_o,
  output core_out_t core_o
);

  //////////////////////////////////////////////////////////////////////////////

  state_t st_q;
  state_t st_d;
  logic pcm;
  logic isa_live;
  logic pcm_live;
  logic card_en;
  logic io_sel;
  logic rd_now;
  logic wr_now;
  logic rom_req;
  logic attr_rd_now;
  logic attr_we_now;
  logic fwe_req;
  logic fcs_req;

  // Pins stand straight on the state flops.
  assign host_o = st_q.pins;
  assign core_o = st_q.core;

  //////////////////////////////////////////////////////////////////////////////

  // Decode of the shared pins and the next state.
  always_comb begin
    st_d = st_q;
    st_d.core.rd = 1'b0;
    st_d.core.wr = 1'b0;
    st_d.core.attr_rd = 1'b0;
    st_d.core.attr_wr = 1'b0;
    pcm = (st_q.mode == MODE_PCMCIA);
    isa_live = st_q.latched && !pcm;
    pcm_live = st_q.latched && pcm;
    // Either card enable selects the card.
    card_en = !host_i.addr[19] || !host_i.sbhe_ce2_n;
    // The I/O window ignores upper address bits in PCMCIA mode.
    if (pcm) begin
      io_sel = !host_i.aen_reg_n && card_en;
    end else begin
      io_sel = !host_i.aen_reg_n && (host_i.addr[15:4] == IO_BASE);
    end
    io_sel = io_sel && st_q.latched;
    rd_now = io_sel && !host_i.iord_n;
    wr_now = io_sel && !host_i.iowr_n;
    rom_req = !host_i.memr_oe_n && (host_i.addr[19:ROM_SHIFT] == ROM_BASE);
    attr_rd_now = pcm_live && !host_i.aen_reg_n && card_en && !host_i.memr_oe_n
      && host_i.addr[ATTR_SPLIT_BIT];
    attr_we_now = pcm_live && !host_i.aen_reg_n && card_en && !host_i.bale_we_n;
    fwe_req = !host_i.bale_we_n && flash_program_enable_bit;
    fcs_req = !host_i.aen_reg_n && !host_i.addr[19] && !host_i.addr[ATTR_SPLIT_BIT];
    if (!st_q.latched) begin
      // First enabled edge after reset takes the strap once.
      st_d.latched = 1'b1;
      st_d.mode = mode_strap_pin_in ? MODE_ISA : MODE_PCMCIA;
      st_d.core.mode_valid = 1'b1;
      st_d.core.pcmcia = !mode_strap_pin_in;
    end else begin
      // Strap pin becomes the boot ROM select in ISA mode only.
      st_d.pins.mode_strap_pin_oe = !pcm;
      st_d.pins.mode_strap_pin_out = pcm || !rom_req;
      // Address 10 and 11 pins turn into flash outputs in PCMCIA mode.
      st_d.pins.a10_oe = pcm;
      st_d.pins.a11_oe = pcm;
      st_d.pins.a10_out = !(pcm && fwe_req);
      st_d.pins.a11_out = !(pcm && fcs_req);
      // Register reads and internal attribute reads own the data bus.
      st_d.pins.data_oe = rd_now || attr_rd_now;
      st_d.pins.data_out = core_rdata;
      // Open drain: only ever pulled low while the core is not ready.
      st_d.pins.ready_out = 1'b0;
      st_d.pins.ready_oe = core_busy && (rd_now || wr_now || attr_rd_now || attr_we_now);
      // Address and byte lanes follow the active cycle.
      if (rd_now || wr_now || attr_rd_now || attr_we_now) begin
        st_d.core.addr = host_i.addr[14:0];
        if (pcm) begin
          st_d.core.be = {!host_i.sbhe_ce2_n, !host_i.addr[19]};
        end else begin
          st_d.core.be = {!host_i.sbhe_ce2_n, !host_i.addr[0]};
        end
      end
      // Write data is sampled while the strobe is low.
      if (wr_now || attr_we_now) begin
        st_d.core.wdata = host_i.data;
      end
      // Reads fire at the strobe's leading edge, writes at its trailing edge.
      st_d.core.rd = rd_now && !st_q.rd_act;
      st_d.core.attr_rd = attr_rd_now && !st_q.rd_act;
      st_d.core.wr = st_q.wr_act && !wr_now;
      st_d.core.attr_wr = st_q.we_act && !attr_we_now;
      st_d.rd_act = rd_now || attr_rd_now;
      st_d.wr_act = wr_now;
      st_d.we_act = attr_we_now;
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= ST_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Checks on the decoder.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence seq_we_low;
    clk_en && st_q.we_act;
  endsequence

  sequence seq_we_release;
    clk_en && !attr_we_now;
  endsequence

  sequence seq_first_edge;
    clk_en && !st_q.latched;
  endsequence

  chk_strap_sample: assert property (
    seq_first_edge |=> st_q.latched
      && (st_q.mode == ($past(mode_strap_pin_in) ? MODE_ISA : MODE_PCMCIA)))
    else $error("Mode does not follow the strap level.");

  chk_mode_hold: assert property (
    st_q.latched |=> st_q.latched && $stable(st_q.mode))
    else $error("Mode changed without a reset.");

  chk_rom_select: assert property (
    (isa_live && clk_en) |=> host_o.mode_strap_pin_oe
      && (host_o.mode_strap_pin_out == !$past(rom_req)))
    else $error("Boot ROM select does not follow MEMR and address.");

  chk_rom_disabled: assert property (
    pcm_live |-> !host_o.mode_strap_pin_oe)
    else $error("Strap pin driven in PCMCIA mode.");

  chk_isa_addr_pins: assert property (
    (isa_live && clk_en) |=> !host_o.a10_oe && !host_o.a11_oe
      && host_o.a10_out && host_o.a11_out)
    else $error("Address 10 or 11 pin driven in ISA mode.");

  chk_flash_write: assert property (
    (pcm_live && clk_en) |=> host_o.a10_oe
      && (host_o.a10_out == !$past(!host_i.bale_we_n && flash_program_enable_bit)))
    else $error("Flash write strobe wrong.");

  chk_flash_select: assert property (
    (pcm_live && clk_en) |=> host_o.a11_oe && (host_o.a11_out == !$past(fcs_req)))
    else $error("Flash chip select wrong.");

  chk_aen_ignore: assert property (
    (isa_live && clk_en && host_i.aen_reg_n) |=> !core_o.rd && !host_o.data_oe)
    else $error("ISA cycle decoded while AEN high.");

  chk_card_enable: assert property (
    (pcm_live && clk_en && host_i.addr[19] && host_i.sbhe_ce2_n) |=> !core_o.rd
      && !core_o.attr_rd && !host_o.data_oe)
    else $error("Card answered with both enables high.");

  chk_attr_write: assert property (
    seq_we_low ##0 seq_we_release |=> core_o.attr_wr)
    else $error("Attribute write lost at WE release.");

  chk_data_drive: assert property (
    (clk_en && !rd_now && !attr_rd_now) |=> !host_o.data_oe)
    else $error("Data bus driven outside a read.");

  chk_wait_cause: assert property (
    host_o.ready_oe |-> $past(core_busy) && !host_o.ready_out)
    else $error("Cycle stretched without a busy core.");

endmodule

// file: tb/host_side_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Host side of the shared pins, with the board resistor that holds the released strap line.
module host_side_model
  import pin_mode_pkg::*;
(
  input wire host_in_t host_drv,
  input wire logic strap_pull,
  input wire host_out_t host_o,
  output host_in_t host_i,
  output logic strap_lvl
);
  // The strap pin follows the device while it drives, else the board resistor.
  assign strap_lvl = host_o.mode_strap_pin_oe ? host_o.mode_strap_pin_out : strap_pull;
  // Host strobes, space select and lane enables pass through; device read data wins the bus.
  always_comb begin
    host_i = host_drv;
    if (host_o.data_oe) begin
      host_i.data = host_o.data_out;
    end
  end
endmodule

// file: tb/isa_pcmcia_host_pin_mode_decode_bench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Random host cycles in both bus modes, the strap, flash, data and ready pin answers compared with a reference.
module isa_pcmcia_host_pin_mode_decode_bench;
  import pin_mode_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap_pull = 1'b1;
  logic prog = 1'b0;
  logic busy = 1'b0;
  logic [15:0] rdata = 16'h0000;
  host_in_t drv = '1;
  host_in_t host_i;
  host_out_t host_o;
  core_out_t core_o;
  logic strap_lvl;
  logic e_rom, e_oe, e_fwe, e_fcs, e_busy;
  logic [15:0] e_data;
  int errors = 0;
  int n_compared = 0;
  int seed = 32'hea30e7c0;

  // Clock of 10 ns period.
  always #5 mclk = ~mclk;

  pin_mode_decode dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .host_i(host_i),
    .mode_strap_pin_in(strap_lvl), .flash_program_enable_bit(prog), .core_busy(busy),
    .core_rdata(rdata), .host_o(host_o), .core_o(core_o));
  host_side_model partner (.host_drv(drv), .strap_pull(strap_pull), .host_o(host_o),
    .host_i(host_i), .strap_lvl(strap_lvl));

  ////////////////////////////////////////////////////////////////////////
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Holds reset for eight cycles with the chosen strap level, then lets the mode latch.
  task automatic do_reset(input logic pull);
    strap_pull = pull;
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // Drives one random cycle, biased toward the I/O and ROM windows, and works out the answer.
  task automatic drive_random(input logic pcm);
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    drv = r[41:0];
    if (r[60]) drv.addr[15:4] = IO_BASE_RST;
    if (r[61]) drv.addr[19:14] = ROM_BASE_RST;
    if (!drv.iord_n) drv.iowr_n = 1'b1;
    busy = r[62];
    prog = r[63];
    rdata = r[79:64];
    if (pcm) strap_pull = r[80];
    e_rom = !(!drv.memr_oe_n && drv.addr[19:14] == ROM_BASE_RST);
    if (pcm) begin
      // Card enabled register read or internal attribute read drives the bus.
      e_oe = !drv.aen_reg_n && (!drv.addr[19] || !drv.sbhe_ce2_n)
        && (!drv.iord_n || (!drv.memr_oe_n && drv.addr[15]));
    end else begin
      e_oe = !drv.aen_reg_n && !drv.iord_n && drv.addr[15:4] == IO_BASE_RST;
    end
    e_fwe = !(!drv.bale_we_n && prog);
    e_fcs = !(!drv.aen_reg_n && !drv.addr[19] && !drv.addr[15]);
    e_busy = busy;
    e_data = rdata;
  endtask

  // Compares the pins one cycle after the inputs were driven.
  task automatic check_cycle(input logic pcm);
    @(posedge mclk);
    #1;
    chk(host_o.ready_out, 1'b0);
    chk({core_o.mode_valid, core_o.pcmcia}, {1'b1, pcm});
    chk(host_o.data_oe, e_oe);
    if (e_oe) begin
      chk(host_o.data_out, e_data);
      chk(host_o.ready_oe, e_busy);
    end
    if (pcm) begin
      chk(host_o.a10_out, e_fwe);
      chk(host_o.a11_out, e_fcs);
      chk({host_o.a10_oe, host_o.a11_oe, host_o.mode_strap_pin_oe}, 3'b110);
      chk(host_o.mode_strap_pin_oe, 1'b0);
    end else begin
      chk(strap_lvl, e_rom);
      chk({host_o.a10_oe, host_o.a11_oe}, 2'b00);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // ISA run with the strap open, then PCMCIA after a second reset with the strap wandering.
  initial begin
    do_reset(1'b1);
    repeat (300) begin
      drive_random(1'b0);
      check_cycle(1'b0);
    end
    do_reset(1'b0);
    repeat (300) begin
      drive_random(1'b1);
      check_cycle(1'b1);
    end
    end_sim();
  end

  // Cuts a hang short well after the expected run of about 620 cycles.
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
